// ==== region_bw_target_regs.sv ====
// How it works
// RULE1 - Region 3 target is RW at bits 56:48 and resets to 1FFh.
// RULE2 - Region 2 target is RW at bits 40:32 and resets to 1FFh.
// RULE3 - Region 1 target is RW at bits 24:16 and resets to 1FFh.
// RULE4 - Region 0 target is RW at bits 8:0 and resets to 1FFh.
// RULE5 - Targets run from 001h (least) to 1FFh (most), monotonic between.
// RULE6 - Register address is base plus (region/4)*512 plus class*8 bytes.
// RULE7 - Bank 0 serves regions 0-3, each next 512-byte bank four more.
// RULE8 - Each bank has one 8-byte slot per class, at most 64 classes.
// RULE9 - The space is made of 4 KB blocks and the block count is reported.
// RULE10 - Software stays below base plus block count times 4096 bytes.
// RULE11 - Software uses this layout only when the reported version is 1.
// RULE12 - Class instances run from zero up to the reported maximum class.
// RULE13 - Every management domain has its own full copy of the bank.
// RULE14 - Reserved bits reset to zero and software keeps their read value.
// RULE15 - Within a register the field used is region number modulo four.
`timescale 1ns/1ps
`default_nettype none
module region_bw_target_regs
    import region_bw_target_pkg::*;
#(
    parameter int NUM_CLASSES = 64,
    parameter int NUM_BANKS   = 2,
    parameter int NUM_DOMAINS = 2,
    parameter int ADDR_W      = 16,
    parameter int REGION_W    = 8
) (
    input  wire logic                           mclk_i,
    input  wire logic                           rst_b_i,
    input  wire logic                           clk_en_i,
    // Register access
    input  wire logic                           mmio_req_i,
    input  wire logic                           mmio_we_i,
    input  wire logic [$clog2(NUM_DOMAINS)-1:0] mmio_domain_i,
    input  wire logic [ADDR_W-1:0]              mmio_addr_i,
    input  wire logic [63:0]                    mmio_wdata_i,
    input  wire logic [7:0]                     mmio_be_i,
    output var  logic [63:0]                    mmio_rdata_o,
    output var  logic                           mmio_ack_o,
    output var  logic                           mmio_err_o,

    // Constants seen by software
    output var  logic [7:0]                     block_count_o,
    output var  logic [7:0]                     index_version_o,

    // Throttle lookup
    input  wire logic [$clog2(NUM_DOMAINS)-1:0] thr_domain_i,
    input  wire logic [5:0]                     thr_class_i,
    input  wire logic [REGION_W-1:0]            thr_region_i,
    output var  logic [8:0]                     thr_target_o
);
    localparam int ENTRIES = NUM_DOMAINS * NUM_BANKS * NUM_CLASSES;
    // Blocks needed to cover every bank
    localparam int BLOCKS  =
        (NUM_BANKS * BANK_STRIDE_BYTES + BLOCK_BYTES - 1) / BLOCK_BYTES;
    localparam logic [7:0] BLOCKS_RST = 8'(BLOCKS);

    // Stored entries pack the four targets without gaps
    localparam int FIELD0_OFF = 0;
    localparam int FIELD1_OFF = TARGET_W;
    localparam int FIELD2_OFF = 2 * TARGET_W;
    localparam int FIELD3_OFF = 3 * TARGET_W;

    typedef struct packed {
        logic [ENTRIES-1:0][ENTRY_W-1:0] target;
        logic [63:0]                     rdata;
        logic                            ack;
        logic                            err;
        logic [8:0]                      thr;
        logic [7:0]                      blocks;
        logic [7:0]                      version;
    } state_s;

    // Every target starts at the highest bandwidth
    localparam state_s RST_STATE = '{
        target:  {ENTRIES{ENTRY_RST}},
        rdata:   64'h0,
        ack:     1'b0,
        err:     1'b0,
        thr:     TARGET_RST,
        blocks:  BLOCKS_RST,
        version: INDEX_FN_VERSION
    };

    state_s r;
    state_s next_r;

    // Reserved bits are never stored, so they always read zero
    function automatic logic [63:0] to_word(input logic [35:0] e);
        logic [63:0] w;
        w = 64'h0;
        w[REGION3_LSB +: TARGET_W] = e[FIELD3_OFF +: TARGET_W]; // RULE1
        w[REGION2_LSB +: TARGET_W] = e[FIELD2_OFF +: TARGET_W]; // RULE2
        w[REGION1_LSB +: TARGET_W] = e[FIELD1_OFF +: TARGET_W]; // RULE3
        w[REGION0_LSB +: TARGET_W] = e[FIELD0_OFF +: TARGET_W]; // RULE4
        return w; // RULE14
    endfunction : to_word

    function automatic logic [35:0] from_word(input logic [63:0] w);
        logic [35:0] e;
        e = 36'h0;
        e[FIELD3_OFF +: TARGET_W] = w[REGION3_LSB +: TARGET_W]; // RULE1
        e[FIELD2_OFF +: TARGET_W] = w[REGION2_LSB +: TARGET_W]; // RULE2
        e[FIELD1_OFF +: TARGET_W] = w[REGION1_LSB +: TARGET_W]; // RULE3
        e[FIELD0_OFF +: TARGET_W] = w[REGION0_LSB +: TARGET_W]; // RULE4
        // Reserved bits of a write are dropped here
        return e; // RULE14
    endfunction : from_word

    // One pass decodes the access and the throttle lookup
    always_comb begin
        int          slot;
        int          bank;
        int          dom;
        int          idx;
        int          tdom;
        int          tclass;
        int          tbank;
        int          tfield;
        int          tidx;
        logic        aligned;
        logic        class_ok;
        logic        bank_ok;
        logic        hit;
        logic        wr_hit;
        logic        rd_hit;
        logic        thr_ok;
        logic [63:0] old_w;
        logic [63:0] new_w;
        logic [8:0]  sel;
        slot     = 0;
        bank     = 0;
        dom      = 0;
        idx      = 0;
        tdom     = 0;
        tclass   = 0;
        tbank    = 0;
        tfield   = 0;
        tidx     = 0;
        aligned  = 1'b0;
        class_ok = 1'b0;
        bank_ok  = 1'b0;
        hit      = 1'b0;
        wr_hit   = 1'b0;
        rd_hit   = 1'b0;
        thr_ok   = 1'b0;
        old_w    = 64'h0;
        new_w    = 64'h0;
        sel      = 9'h0;
        next_r   = r;

        // Register access decode
        slot     = int'(mmio_addr_i[BANK_LSB-1:SLOT_LSB]); // RULE8
        bank     = int'(mmio_addr_i[ADDR_W-1:BANK_LSB]); // RULE7
        dom      = int'(mmio_domain_i); // RULE13
        aligned  = (mmio_addr_i[SLOT_LSB-1:0] == 3'h0);
        class_ok = (slot < NUM_CLASSES); // RULE12
        bank_ok  = (bank < NUM_BANKS); // RULE9
        hit      = aligned && class_ok && bank_ok;
        // A refused access leaves every register untouched
        wr_hit   = mmio_req_i && mmio_we_i && hit;
        rd_hit   = mmio_req_i && !mmio_we_i && hit;
        if (hit) begin
            idx   = (dom * NUM_BANKS + bank) * NUM_CLASSES + slot; // RULE6
            old_w = to_word(r.target[idx]);
        end

        new_w = old_w;
        // Unselected byte lanes keep the stored value
        for (int b = 0; b < 8; b++) begin
            if (mmio_be_i[b]) begin
                new_w[8*b +: 8] = mmio_wdata_i[8*b +: 8];
            end
        end

        // Answers stand for one enabled cycle only
        next_r.ack   = mmio_req_i;
        next_r.err   = mmio_req_i && !hit;
        next_r.rdata = 64'h0;
        if (wr_hit) begin
            next_r.target[idx] = from_word(new_w);
        end
        if (rd_hit) begin
            next_r.rdata = old_w;
        end

        // Throttle lookup, out of range reads as the least bandwidth, 001h
        tdom   = int'(thr_domain_i); // RULE13
        tclass = int'(thr_class_i);
        tbank  = int'(thr_region_i) / REGIONS_PER_BANK; // RULE7
        tfield = int'(thr_region_i[1:0]); // RULE15
        thr_ok = (tclass < NUM_CLASSES) && (tbank < NUM_BANKS);
        if (thr_ok) begin
            tidx = (tdom * NUM_BANKS + tbank) * NUM_CLASSES + tclass;
            sel  = r.target[tidx][TARGET_W*tfield +: TARGET_W]; // RULE15
        end

        // Zero is outside the legal range, treated as the least bandwidth
        if (sel == 9'h0) begin
            next_r.thr = TARGET_MIN; // RULE5
        end else begin
            next_r.thr = sel;
        end
    end

    // Low enable freezes every flop, answers included
    always_ff @(posedge mclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            r <= RST_STATE;
        end else if (clk_en_i) begin
            r <= next_r;
        end
    end

    // Outputs come straight from the state flops
    assign mmio_rdata_o    = r.rdata;
    assign mmio_ack_o      = r.ack;
    assign mmio_err_o      = r.err;
    assign block_count_o   = r.blocks; // RULE9
    assign index_version_o = r.version; // RULE11
    assign thr_target_o    = r.thr;
endmodule : region_bw_target_regs
`default_nettype wire

// ==== region_bw_target_pkg.sv ====
package region_bw_target_pkg;
    localparam int          BANK_STRIDE_BYTES = 512;
    localparam int          SLOT_BYTES        = 8;
    localparam int          BLOCK_BYTES       = 4096;
    localparam int          REGIONS_PER_BANK  = 4;
    localparam int          SLOT_LSB          = 3;
    localparam int          BANK_LSB          = 9;
    localparam int          TARGET_W          = 9;
    localparam int          REGION0_LSB       = 0;
    localparam int          REGION1_LSB       = 16;
    localparam int          REGION2_LSB       = 32;
    localparam int          REGION3_LSB       = 48;
    localparam logic [8:0]  TARGET_RST        = 9'h1FF;
    localparam logic [8:0]  TARGET_MIN        = 9'h001;
    localparam logic [7:0]  INDEX_FN_VERSION  = 8'h01;
    localparam int          ENTRY_W           = REGIONS_PER_BANK * TARGET_W;
    localparam logic [35:0] ENTRY_RST         = {4{TARGET_RST}};
endpackage : region_bw_target_pkg

// ==== region_bw_chk_sva.sv ====
`timescale 1ns/1ps
`default_nettype none
module region_bw_chk #(
    parameter int ADDR_W    = 16,
    parameter int NUM_BANKS = 2
) (
    input wire logic              mclk_i,
    input wire logic              rst_b_i,
    input wire logic              clk_en_i,
    input wire logic              mmio_req_i,
    input wire logic              mmio_we_i,
    input wire logic [ADDR_W-1:0] mmio_addr_i,
    input wire logic [63:0]       mmio_rdata_o,
    input wire logic              mmio_ack_o,
    input wire logic              mmio_err_o,
    input wire logic [7:0]        block_count_o,
    input wire logic [7:0]        index_version_o,
    input wire logic [8:0]        thr_target_o
);
    default clocking @(posedge mclk_i); endclocking
    default disable iff (!rst_b_i);
    ack_after_req_a: assert property (
        clk_en_i && mmio_req_i |=> mmio_ack_o)
        else $error("missing ack");
    ack_no_cause_a: assert property (
        clk_en_i && !mmio_req_i |=> !mmio_ack_o)
        else $error("ack without request");
    misalign_err_a: assert property (
        clk_en_i && mmio_req_i && mmio_addr_i[2:0] != 3'h0 |=> mmio_err_o)
        else $error("misaligned not refused");
    bank_range_a: assert property (
        clk_en_i && mmio_req_i && mmio_addr_i[ADDR_W-1:9] >= NUM_BANKS
        |=> mmio_err_o && mmio_rdata_o == 64'h0)
        else $error("bank range not refused");
    write_quiet_a: assert property (
        clk_en_i && mmio_req_i && mmio_we_i |=> mmio_rdata_o == 64'h0)
        else $error("write returned data");
    rsvd_read_a: assert property (mmio_ack_o
        |-> (mmio_rdata_o & 64'hFE00_FE00_FE00_FE00) == 64'h0)
        else $error("reserved bits set");
    block_count_a: assert property (block_count_o
        == 8'((NUM_BANKS * 512 + 4095) / 4096)) else $error("bad block count");
    version_one_a: assert property (index_version_o == 8'h01)
        else $error("bad version");
    target_floor_a: assert property (thr_target_o != 9'h000)
        else $error("target below floor");
endmodule : region_bw_chk
bind region_bw_target_regs region_bw_chk #(.ADDR_W(ADDR_W),
    .NUM_BANKS(NUM_BANKS)) region_bw_chk_inst (.*);
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/1ps
`default_nettype none
module testbench;
    import region_bw_target_pkg::*;
    logic        mclk = 1'b0, rst_b = 1'b0, req = 1'b0, we = 1'b0, dom = 1'b0;
    logic        tdom = 1'b0, en = 1'b1, ack, err;
    logic [15:0] addr = 16'h0;
    logic [63:0] wd = 64'h0, rd, shadow [2][128];
    logic [7:0]  be = 8'h0, treg = 8'h0, blk, ver;
    logic [5:0]  tcls = 6'h0;
    logic [8:0]  tgt, f;
    logic [64:0] expq [$];
    int          err_total = 0, n_checks = 0;
    region_bw_target_regs region_bw_target_regs_inst (.mclk_i(mclk),
        .rst_b_i(rst_b), .clk_en_i(en), .mmio_req_i(req), .mmio_we_i(we),
        .mmio_domain_i(dom), .mmio_addr_i(addr), .mmio_wdata_i(wd),
        .mmio_be_i(be), .mmio_rdata_o(rd), .mmio_ack_o(ack), .mmio_err_o(err),
        .block_count_o(blk), .index_version_o(ver), .thr_domain_i(tdom),
        .thr_class_i(tcls), .thr_region_i(treg), .thr_target_o(tgt));
    initial forever #5 mclk = ~mclk;
    task automatic chk(input logic [64:0] seen, input logic [64:0] exp);
        n_checks++;
        if (seen !== exp) begin
            err_total++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask : chk
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0) $display("Testbench passed");
        else $display("Testbench failed");
        $finish;
    endtask : conclude
    // Model merges byte lanes, then drops reserved bits
    task automatic acc(input logic w, input logic d, input logic [15:0] a,
                       input logic [63:0] v, input logic [7:0] b);
        logic [64:0] e;
        e = 65'h0;
        @(posedge mclk);
        req <= 1'b1; we <= w; dom <= d; addr <= a; wd <= v; be <= b;
        if (a[2:0] != 3'h0 || a[15:9] > 7'h1) e[64] = 1'b1;
        else if (w) begin
            for (int k = 0; k < 8; k++) begin
                if (b[k]) shadow[d][a[9:3]][8*k+:8] = v[8*k+:8];
            end
            shadow[d][a[9:3]] &= 64'h01FF_01FF_01FF_01FF;
        end else e[63:0] = shadow[d][a[9:3]];
        expq.push_back(e);
    endtask : acc
    always @(negedge mclk) begin
        if (ack === 1'b1) chk({err, rd}, expq.pop_front());
    end
    initial begin
        #50000 err_total++;
        conclude();
    end
    initial begin
        logic [15:0] ra;
        logic        rdom;
        void'($urandom(24776));
        foreach (shadow[d, i]) shadow[d][i] = 64'h01FF_01FF_01FF_01FF;
        repeat (4) @(posedge mclk);
        rst_b <= 1'b1;
        #1 chk(65'(blk), 65'((2 * BANK_STRIDE_BYTES + BLOCK_BYTES - 1)
                             / BLOCK_BYTES));
        chk(65'(ver), 65'(INDEX_FN_VERSION));
        chk(65'(tgt), 65'(TARGET_RST));
        acc(1'b1, 1'b1, 16'h03F8, 64'h0, 8'h00);
        acc(1'b0, 1'b1, 16'h03F8, 64'h0, 8'h00);
        acc(1'b0, 1'b0, 16'h0000, 64'h0, 8'h00);
        acc(1'b1, 1'b0, 16'h0000, 64'h0, 8'h03);
        repeat (40) begin
            ra   = {6'h0, 1'($urandom), 6'($urandom), 3'h0};
            rdom = 1'($urandom);
            acc(1'b1, rdom, ra, {$urandom, $urandom},
                8'($urandom));
            acc(1'b0, rdom, ra, 64'h0, 8'h00);
        end
        acc(1'b1, 1'b0, 16'h0004, '1, 8'hFF);
        acc(1'b0, 1'b0, 16'h0400, 64'h0, 8'h00);
        @(posedge mclk) req <= 1'b0;
        for (int n = 0; n < 24; n++) begin
            tdom <= n == 0 ? 1'b0 : 1'($urandom);
            tcls <= n == 0 ? 6'h0 : 6'($urandom);
            treg <= n == 0 ? 8'h0 : 8'($urandom_range(7));
            repeat (2) @(posedge mclk);
            #1 f = shadow[tdom][{treg[2], tcls}][16*treg[1:0]+:9];
            chk({56'h0, tgt}, {56'h0, f == 9'h0 ? 9'h001 : f});
        end
        @(posedge mclk);
        en   <= 1'b0;
        req  <= 1'b1;
        we   <= 1'b0;
        addr <= 16'h0;
        repeat (3) @(posedge mclk);
        #1 chk(65'(ack), 65'h0);
        @(posedge mclk);
        req <= 1'b0;
        en  <= 1'b1;
        repeat (2) @(posedge mclk);
        #1 chk(65'(ack), 65'h0);
        conclude();
    end
endmodule : testbench
`default_nettype wire
